// *** rtl/psd_pkg.sv ***
// Contract
// R1: supervisor when level 01, flags clear, no debug; code treats level 01 as user in fixed mapper builds
// R2: supervisor allows user and supervisor windows only
// R3: supervisor windows go through translator or mapper
// R4: identifier appended to mapped translation-buffer lookups; code sends window 111 lookups without it
// R5: fixed mapper caching from user, upper-kernel attrs
// R6: kernel when level 00 or error/exception flag
// R7: non-debug exception sets exception or error flag
// R8: return jumps saved pc, clears error, maybe exception
// R9: kernel low half mapped with identifier
// R10: error flag makes low half unmapped, uncached
// R11: window 100 unmapped, minus 0x8000_0000, window0 attr
// R12: window 101 unmapped, minus 0xA000_0000, uncached
// R13: window 110 mapped, or identity in mapper
// R14: window 111 mapped, or identity in mapper
// R15: user when level 10; only low half legal
// R16: fixed mapper applies no write protection
// R17: flags, caching, physical address leave together
package psd_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] PSD_CTRL_OFS = 8'h00;
  localparam logic [7:0] PSD_CACHE_OFS = 8'h04;
  localparam logic [7:0] PSD_STATE_OFS = 8'h08;
  localparam logic [7:0] PSD_EPC_OFS = 8'h0c;
  localparam logic [7:0] PSD_IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] PSD_IRQ_MASK_OFS = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PSD_LVL_LSB = 0;   // privilege_level_field, 2 bits
  localparam int PSD_EXL_BIT = 2;   // exception_level_flag
  localparam int PSD_ERL_BIT = 3;   // error_level_flag
  localparam int PSD_DBG_BIT = 4;   // debug_active_flag
  localparam int PSD_ADDRESS_SPACE_IDENTIFIER_LSB = 8;  // address_space_identifier, 8 bits
  localparam int PSD_K0_LSB = 0;    // kernel_window0_cache_attr
  localparam int PSD_KU_LSB = 4;    // user_window_cache_attr
  localparam int PSD_K23_LSB = 8;   // upper_kernel_cache_attr
  localparam int PSD_FIXED_BIT = 2; // state register: fixed mapper build
  localparam int PSD_IRQ_ADE = 0;   // address error seen
  localparam int PSD_IRQ_EXC = 1;   // exception taken
  localparam int PSD_IRQ_RET = 2;   // exception return taken
  localparam int PSD_IRQ_W = 3;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [31:0] PSD_CTRL_RST = 32'h0000_0008; // kernel, error flag set
  localparam logic [31:0] PSD_CACHE_RST = 32'h0000_0222; // all uncached
  localparam logic [2:0] PSD_ATTR_UNCACHED = 3'h2;
  localparam logic [1:0] PSD_LVL_KERNEL = 2'h0;
  localparam logic [1:0] PSD_LVL_SUPER = 2'h1;
  localparam logic [1:0] PSD_LVL_USER = 2'h2;

  // ----------------------------------------------------------------
  // address windows
  // ----------------------------------------------------------------
  localparam logic [2:0] PSD_WIN_K0 = 3'h4;
  localparam logic [2:0] PSD_WIN_K1 = 3'h5;
  localparam logic [2:0] PSD_WIN_KA = 3'h6;
  localparam logic [2:0] PSD_WIN_KB = 3'h7;
  localparam logic [31:0] PSD_K0_BASE = 32'h8000_0000;
  localparam logic [31:0] PSD_K1_BASE = 32'ha000_0000;

endpackage : psd_pkg

// *** rtl/psd_privilege_segment_decoder.sv ***
`timescale 1ns/1ps
module psd_privilege_segment_decoder #(
  parameter bit FIXED_MAP = 1'b0,
  parameter logic [31:0] FM_USEG_OFFSET = 32'h0000_0000,
  parameter int ADDRESS_SPACE_IDENTIFIER_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pipeline address request
  input wire logic req_valid_i,
  input wire logic [31:0] req_va_i,
  input wire logic req_write_i,
  // pipeline exception events
  input wire logic exc_take_i,
  input wire logic exc_error_class_i,
  input wire logic exc_debug_i,
  input wire logic [31:0] exc_pc_i,
  input wire logic exception_return_instr_i,
  // decode result towards translator, mapper and cache
  output logic rsp_valid_o,
  output logic rsp_legal_o,
  output logic rsp_addr_err_o,
  output logic rsp_mapped_o,
  output logic rsp_use_address_space_identifier_o,
  output logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] rsp_address_space_identifier_o,
  output logic rsp_pa_valid_o,
  output logic [31:0] rsp_pa_o,
  output logic rsp_cached_o,
  output logic rsp_write_o,
  // return redirect
  output logic redirect_valid_o,
  output logic [31:0] redirect_pc_o,
  // interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDRESS_SPACE_IDENTIFIER_W != 8) begin : g_bad_address_space_identifier
    $error("address space identifier width must be 8");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0] lvl_ff;
  logic exl_ff;
  logic erl_ff;
  logic dbg_ff;
  logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] address_space_identifier_ff;
  logic [2:0] k0_attr_ff;
  logic [2:0] ku_attr_ff;
  logic [2:0] k23_attr_ff;
  logic [31:0] epc_ff;
  logic [psd_pkg::PSD_IRQ_W-1:0] irq_stat_ff;
  logic [psd_pkg::PSD_IRQ_W-1:0] irq_mask_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;

  // bus strobes: a write commits on the edge where ack is high
  logic wb_req;
  logic wb_wr;
  logic [31:0] ctrl_rd;
  logic [31:0] cache_rd;
  logic [31:0] state_rd;

  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr = wb_req & wb_we_i & ack_ff;

  // ----------------------------------------------------------------
  // privilege mode
  // ----------------------------------------------------------------
  logic is_super;
  logic is_user;
  logic is_kernel;

  // debug reuses the kernel map; reserved level 11 is held as user
  always_comb begin
    is_super = (lvl_ff == psd_pkg::PSD_LVL_SUPER) & ~exl_ff & ~erl_ff & ~dbg_ff // R1
             & ~FIXED_MAP;
    is_kernel = dbg_ff | exl_ff | erl_ff | (lvl_ff == psd_pkg::PSD_LVL_KERNEL); // R6
    is_user = ~is_kernel & ~is_super; // R15
  end

  // ----------------------------------------------------------------
  // segment decode
  // ----------------------------------------------------------------
  logic nxt_legal;
  logic nxt_mapped;
  logic nxt_use_address_space_identifier;
  logic nxt_pa_valid;
  logic [31:0] nxt_pa;
  logic nxt_cached;
  logic [2:0] win;

  assign win = req_va_i[31:29];

  always_comb begin
    nxt_legal = 1'b0;
    nxt_mapped = 1'b0;
    nxt_use_address_space_identifier = 1'b0;
    nxt_pa_valid = 1'b0;
    nxt_pa = 32'h0000_0000;
    nxt_cached = 1'b0;
    if (!req_va_i[31]) begin
      nxt_legal = 1'b1; // R15
      if (is_kernel && erl_ff) begin
        nxt_pa_valid = 1'b1; // R10
        nxt_pa = req_va_i; // R10
      end else begin
        nxt_mapped = 1'b1; // R3 R9
        nxt_use_address_space_identifier = ~FIXED_MAP; // R4 R9
        nxt_pa_valid = FIXED_MAP;
        nxt_pa = FIXED_MAP ? req_va_i + FM_USEG_OFFSET : 32'h0000_0000;
        nxt_cached = FIXED_MAP & (ku_attr_ff != psd_pkg::PSD_ATTR_UNCACHED); // R5
      end
    end else if (is_kernel && win == psd_pkg::PSD_WIN_K0) begin
      nxt_legal = 1'b1;
      nxt_pa_valid = 1'b1;
      nxt_pa = req_va_i - psd_pkg::PSD_K0_BASE; // R11
      nxt_cached = k0_attr_ff != psd_pkg::PSD_ATTR_UNCACHED; // R11
    end else if (is_kernel && win == psd_pkg::PSD_WIN_K1) begin
      nxt_legal = 1'b1;
      nxt_pa_valid = 1'b1;
      nxt_pa = req_va_i - psd_pkg::PSD_K1_BASE; // R12
    end else if ((is_kernel || is_super) && win == psd_pkg::PSD_WIN_KA) begin
      nxt_legal = 1'b1; // R2
      nxt_mapped = 1'b1; // R3 R13
      nxt_use_address_space_identifier = ~FIXED_MAP; // R4
      nxt_pa_valid = FIXED_MAP;
      nxt_pa = FIXED_MAP ? req_va_i : 32'h0000_0000; // R13
      nxt_cached = FIXED_MAP & (k23_attr_ff != psd_pkg::PSD_ATTR_UNCACHED); // R5
    end else if (is_kernel && win == psd_pkg::PSD_WIN_KB) begin
      nxt_legal = 1'b1;
      nxt_mapped = 1'b1; // R14
      nxt_pa_valid = FIXED_MAP;
      nxt_pa = FIXED_MAP ? req_va_i : 32'h0000_0000; // R14
      nxt_cached = FIXED_MAP & (k23_attr_ff != psd_pkg::PSD_ATTR_UNCACHED);
    end
  end

  // result register; all fields move together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_legal_o <= 1'b0;
      rsp_addr_err_o <= 1'b0;
      rsp_mapped_o <= 1'b0;
      rsp_use_address_space_identifier_o <= 1'b0;
      rsp_address_space_identifier_o <= '0;
      rsp_pa_valid_o <= 1'b0;
      rsp_pa_o <= 32'h0000_0000;
      rsp_cached_o <= 1'b0;
      rsp_write_o <= 1'b0;
    end else begin
      rsp_valid_o <= req_valid_i; // R17
      rsp_legal_o <= req_valid_i & nxt_legal; // R17
      rsp_addr_err_o <= req_valid_i & ~nxt_legal; // R2
      rsp_mapped_o <= req_valid_i & nxt_mapped;
      rsp_use_address_space_identifier_o <= req_valid_i & nxt_use_address_space_identifier;
      rsp_address_space_identifier_o <= nxt_use_address_space_identifier ? address_space_identifier_ff : '0; // R4
      rsp_pa_valid_o <= req_valid_i & nxt_pa_valid;
      rsp_pa_o <= nxt_pa;
      rsp_cached_o <= req_valid_i & nxt_cached;
      // no protection check in the mapper: writes simply pass on
      rsp_write_o <= req_valid_i & req_write_i & nxt_legal; // R16
    end
  end

  // ----------------------------------------------------------------
  // control flags: software writes, then hardware events win
  // ----------------------------------------------------------------
  logic exc_hit;
  logic ret_hit;

  assign exc_hit = exc_take_i & ~exc_debug_i;
  assign ret_hit = exception_return_instr_i & ~exc_hit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_ff <= psd_pkg::PSD_CTRL_RST[psd_pkg::PSD_LVL_LSB +: 2];
      dbg_ff <= psd_pkg::PSD_CTRL_RST[psd_pkg::PSD_DBG_BIT];
      address_space_identifier_ff <= psd_pkg::PSD_CTRL_RST[psd_pkg::PSD_ADDRESS_SPACE_IDENTIFIER_LSB +: ADDRESS_SPACE_IDENTIFIER_W];
    end else if (wb_wr && wb_adr_i == psd_pkg::PSD_CTRL_OFS) begin
      if (wb_sel_i[0]) begin
        lvl_ff <= wb_dat_i[psd_pkg::PSD_LVL_LSB +: 2];
        dbg_ff <= wb_dat_i[psd_pkg::PSD_DBG_BIT];
      end
      if (wb_sel_i[1]) begin
        address_space_identifier_ff <= wb_dat_i[psd_pkg::PSD_ADDRESS_SPACE_IDENTIFIER_LSB +: ADDRESS_SPACE_IDENTIFIER_W];
      end
    end
  end

  // exception entry and return override a same-cycle software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exl_ff <= psd_pkg::PSD_CTRL_RST[psd_pkg::PSD_EXL_BIT];
      erl_ff <= psd_pkg::PSD_CTRL_RST[psd_pkg::PSD_ERL_BIT];
    end else if (exc_hit) begin
      if (exc_error_class_i) begin
        erl_ff <= 1'b1; // R7
      end else begin
        exl_ff <= 1'b1; // R7
      end
    end else if (ret_hit) begin
      erl_ff <= 1'b0; // R8
      if (!erl_ff) begin
        exl_ff <= 1'b0; // R8
      end
    end else if (wb_wr && wb_adr_i == psd_pkg::PSD_CTRL_OFS && wb_sel_i[0]) begin
      exl_ff <= wb_dat_i[psd_pkg::PSD_EXL_BIT];
      erl_ff <= wb_dat_i[psd_pkg::PSD_ERL_BIT];
    end
  end

  // saved pc: exception capture beats software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      epc_ff <= 32'h0000_0000;
    end else if (exc_hit) begin
      epc_ff <= exc_pc_i;
    end else if (wb_wr && wb_adr_i == psd_pkg::PSD_EPC_OFS) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          epc_ff[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  // return redirect pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      redirect_valid_o <= 1'b0;
      redirect_pc_o <= 32'h0000_0000;
    end else begin
      redirect_valid_o <= ret_hit; // R8
      redirect_pc_o <= epc_ff; // R8
    end
  end

  // cache attributes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      k0_attr_ff <= psd_pkg::PSD_CACHE_RST[psd_pkg::PSD_K0_LSB +: 3];
      ku_attr_ff <= psd_pkg::PSD_CACHE_RST[psd_pkg::PSD_KU_LSB +: 3];
      k23_attr_ff <= psd_pkg::PSD_CACHE_RST[psd_pkg::PSD_K23_LSB +: 3];
    end else if (wb_wr && wb_adr_i == psd_pkg::PSD_CACHE_OFS) begin
      if (wb_sel_i[0]) begin
        k0_attr_ff <= wb_dat_i[psd_pkg::PSD_K0_LSB +: 3];
        ku_attr_ff <= wb_dat_i[psd_pkg::PSD_KU_LSB +: 3];
      end
      if (wb_sel_i[1]) begin
        k23_attr_ff <= wb_dat_i[psd_pkg::PSD_K23_LSB +: 3];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [psd_pkg::PSD_IRQ_W-1:0] irq_evt;
  logic [psd_pkg::PSD_IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_evt = '0;
    irq_evt[psd_pkg::PSD_IRQ_ADE] = req_valid_i & ~nxt_legal;
    irq_evt[psd_pkg::PSD_IRQ_EXC] = exc_hit;
    irq_evt[psd_pkg::PSD_IRQ_RET] = ret_hit;
    irq_clr = '0;
    if (wb_wr && wb_adr_i == psd_pkg::PSD_IRQ_STAT_OFS && wb_sel_i[0]) begin
      irq_clr = wb_dat_i[psd_pkg::PSD_IRQ_W-1:0];
    end
  end

  // set beats a same-cycle write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_ff <= '0;
    end else if (wb_wr && wb_adr_i == psd_pkg::PSD_IRQ_MASK_OFS && wb_sel_i[0]) begin
      irq_mask_ff <= wb_dat_i[psd_pkg::PSD_IRQ_W-1:0];
    end
  end

  // registered, so the line lags the status bit by one edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // wishbone answer: one wait state, unmapped reads give zero
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[psd_pkg::PSD_LVL_LSB +: 2] = lvl_ff;
    ctrl_rd[psd_pkg::PSD_EXL_BIT] = exl_ff;
    ctrl_rd[psd_pkg::PSD_ERL_BIT] = erl_ff;
    ctrl_rd[psd_pkg::PSD_DBG_BIT] = dbg_ff;
    ctrl_rd[psd_pkg::PSD_ADDRESS_SPACE_IDENTIFIER_LSB +: ADDRESS_SPACE_IDENTIFIER_W] = address_space_identifier_ff;
    cache_rd = 32'h0000_0000;
    cache_rd[psd_pkg::PSD_K0_LSB +: 3] = k0_attr_ff;
    cache_rd[psd_pkg::PSD_KU_LSB +: 3] = ku_attr_ff;
    cache_rd[psd_pkg::PSD_K23_LSB +: 3] = k23_attr_ff;
    state_rd = 32'h0000_0000;
    state_rd[1:0] = is_kernel ? psd_pkg::PSD_LVL_KERNEL :
                    is_super ? psd_pkg::PSD_LVL_SUPER : psd_pkg::PSD_LVL_USER;
    state_rd[psd_pkg::PSD_FIXED_BIT] = FIXED_MAP;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req & ~ack_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h0000_0000;
    end else if (wb_req && !ack_ff) begin
      if (wb_adr_i == psd_pkg::PSD_CTRL_OFS) begin
        rdat_ff <= ctrl_rd;
      end else if (wb_adr_i == psd_pkg::PSD_CACHE_OFS) begin
        rdat_ff <= cache_rd;
      end else if (wb_adr_i == psd_pkg::PSD_STATE_OFS) begin
        rdat_ff <= state_rd;
      end else if (wb_adr_i == psd_pkg::PSD_EPC_OFS) begin
        rdat_ff <= epc_ff;
      end else if (wb_adr_i == psd_pkg::PSD_IRQ_STAT_OFS) begin
        rdat_ff <= {29'h0, irq_stat_ff};
      end else if (wb_adr_i == psd_pkg::PSD_IRQ_MASK_OFS) begin
        rdat_ff <= {29'h0, irq_mask_ff};
      end else begin
        rdat_ff <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

endmodule : psd_privilege_segment_decoder

// *** sim/psd_pipe_model.sv ***
`timescale 1ns/1ps
module psd_pipe_model (
  input wire logic clk_i,
  output logic req_valid_o,
  output logic [31:0] req_va_o,
  output logic req_write_o,
  output logic exc_take_o,
  output logic exc_error_class_o,
  output logic exc_debug_o,
  output logic [31:0] exc_pc_o,
  output logic ret_o
);
  // ----------------------------------------------------------------
  // pipeline stand-in
  // ----------------------------------------------------------------
  // quiet pipeline at time zero
  initial begin
    {req_valid_o, req_write_o, exc_take_o, exc_error_class_o, exc_debug_o, ret_o} = 6'h00;
    req_va_o = 32'h0;
    exc_pc_o = 32'h0;
  end

  // one address per call, held one cycle; lines flipped once released
  task automatic issue(input logic [31:0] va, input logic wr);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_va_o <= va;
    req_write_o <= wr;
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_va_o <= ~va;
    req_write_o <= ~wr;
  endtask : issue

  // one-cycle exception and return pulses
  task automatic ev(input logic t, input logic e, input logic d, input logic [31:0] pc,
    input logic r);
    @(posedge clk_i);
    exc_take_o <= t;
    exc_error_class_o <= e;
    exc_debug_o <= d;
    exc_pc_o <= pc;
    ret_o <= r;
    @(posedge clk_i);
    exc_take_o <= 1'b0;
    ret_o <= 1'b0;
    exc_pc_o <= ~pc;
  endtask : ev
endmodule : psd_pipe_model

// *** sim/psd_checker_sva.sv ***
`timescale 1ns/1ps
module psd_checker_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input logic wb_ack_o,
  input wire logic req_valid_i,
  input wire logic [31:0] req_va_i,
  input wire logic req_write_i,
  input wire logic exc_take_i,
  input wire logic exc_debug_i,
  input wire logic exception_return_instr_i,
  input logic rsp_valid_o,
  input logic rsp_legal_o,
  input logic rsp_addr_err_o,
  input logic rsp_mapped_o,
  input logic rsp_pa_valid_o,
  input logic [31:0] rsp_pa_o,
  input logic rsp_cached_o,
  input logic rsp_write_o,
  input logic redirect_valid_o
);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // request into a window, answered as legal
  sequence legal_in_s(logic [2:0] w);
    req_valid_i && req_va_i[31:29] == w ##1 rsp_legal_o;
  endsequence

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_wb_ack_once: assert property (wb_req_s |=> ack_pulse_s)
    else $error("bus ack is not a single pulse");
  chk_rsp_follows: assert property (req_valid_i |=> rsp_valid_o)
    else $error("decode answer missing");
  chk_rsp_cause: assert property (rsp_valid_o |-> $past(req_valid_i))
    else $error("decode answer without request");
  chk_one_verdict: assert property (rsp_valid_o |-> rsp_legal_o ^ rsp_addr_err_o)
    else $error("legal and error flags disagree");
  chk_win0_offset: assert property (legal_in_s(3'h4) |-> !rsp_mapped_o && rsp_pa_valid_o
    && rsp_pa_o == $past(req_va_i) - 32'h8000_0000)
    else $error("window 0 physical address wrong");
  chk_win1_uncached: assert property (legal_in_s(3'h5) |-> !rsp_cached_o && !rsp_mapped_o
    && rsp_pa_o == $past(req_va_i) - 32'ha000_0000)
    else $error("window 1 decode wrong");
  chk_win_a_mapped: assert property (legal_in_s(3'h6) |-> rsp_mapped_o)
    else $error("window a not mapped");
  chk_win_b_mapped: assert property (legal_in_s(3'h7) |-> rsp_mapped_o)
    else $error("window b not mapped");
  chk_legal_write: assert property (req_valid_i && req_write_i ##1 rsp_legal_o |-> rsp_write_o)
    else $error("legal store lost");
  chk_ret_redirect: assert property (exception_return_instr_i && !(exc_take_i && !exc_debug_i)
    |=> redirect_valid_o)
    else $error("return gave no redirect");
endmodule : psd_checker_sva

bind psd_privilege_segment_decoder psd_checker_sva chk_u (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .req_valid_i, .req_va_i, .req_write_i, .exc_take_i, .exc_debug_i,
  .exception_return_instr_i, .rsp_valid_o, .rsp_legal_o, .rsp_addr_err_o, .rsp_mapped_o,
  .rsp_pa_valid_o, .rsp_pa_o, .rsp_cached_o, .rsp_write_o, .redirect_valid_o);

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, req_va_i, exc_pc_i, rsp_pa_o, redirect_pc_o, rd_d;
  logic wb_ack_o, req_valid_i, req_write_i, exc_take_i, exc_error_class_i, exc_debug_i;
  logic exception_return_instr_i, rsp_valid_o, rsp_legal_o, rsp_addr_err_o, rsp_mapped_o;
  logic rsp_use_address_space_identifier_o, rsp_pa_valid_o, rsp_cached_o, rsp_write_o, redirect_valid_o, irq_o;
  logic [7:0] rsp_address_space_identifier_o;
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
  logic [31:0] rv [7] = '{32'h8, 32'h222, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  int errors = 0;
  int samples_checked = 0;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  psd_pipe_model pipe_u (.clk_i(clk_i), .req_valid_o(req_valid_i), .req_va_o(req_va_i),
    .req_write_o(req_write_i), .exc_take_o(exc_take_i), .exc_error_class_o(exc_error_class_i),
    .exc_debug_o(exc_debug_i), .exc_pc_o(exc_pc_i), .ret_o(exception_return_instr_i));
  psd_privilege_segment_decoder dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i),
    .req_va_i(req_va_i), .req_write_i(req_write_i), .exc_take_i(exc_take_i),
    .exc_error_class_i(exc_error_class_i), .exc_debug_i(exc_debug_i), .exc_pc_i(exc_pc_i),
    .exception_return_instr_i(exception_return_instr_i), .rsp_valid_o(rsp_valid_o),
    .rsp_legal_o(rsp_legal_o), .rsp_addr_err_o(rsp_addr_err_o), .rsp_mapped_o(rsp_mapped_o),
    .rsp_use_address_space_identifier_o(rsp_use_address_space_identifier_o), .rsp_address_space_identifier_o(rsp_address_space_identifier_o), .rsp_pa_valid_o(rsp_pa_valid_o),
    .rsp_pa_o(rsp_pa_o), .rsp_cached_o(rsp_cached_o), .rsp_write_o(rsp_write_o),
    .redirect_valid_o(redirect_valid_o), .redirect_pc_o(redirect_pc_o), .irq_o(irq_o));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // classic wishbone cycle; read data lands in rd_d
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    // ack read in the edge's own time step: the value the slave samples
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd_d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  // flags {legal,err,mapped,pa_valid,cached,write}; refused ones only judge the verdict
  task automatic dec(input logic [31:0] va, input logic wr, input logic [5:0] ef,
    input logic [8:0] ea, input logic [31:0] pa);
    logic [15:0] m;
    pipe_u.issue(va, wr);
    #1;
    m = ef[5] ? 16'hffff : 16'h0070;
    check({16'h0, m & {rsp_use_address_space_identifier_o, rsp_address_space_identifier_o, rsp_valid_o, rsp_legal_o, rsp_addr_err_o,
      rsp_mapped_o, rsp_pa_valid_o, rsp_cached_o, rsp_write_o}}, {16'h0, m & {ea, 1'b1, ef}});
    if (ef[2]) check(rsp_pa_o, pa);
  endtask : dec

  task automatic results;
    $display("checked %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  // the run takes well under 1000 cycles, so this only trips on a hang
  initial begin
    #100000;
    errors++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, ra[i], 32'h0);
      check(rd_d, rv[i]);
    end
    $display("reset test done");
    dec(32'h1234_5678, 1'b0, 6'h24, 9'h000, 32'h1234_5678);
    dec(32'h8000_1000, 1'b0, 6'h24, 9'h000, 32'h0000_1000);
    bus(1'b1, psd_pkg::PSD_CACHE_OFS, 32'h0000_0223);
    dec(32'h9fff_fffc, 1'b0, 6'h26, 9'h000, 32'h1fff_fffc);
    dec(32'ha000_2000, 1'b0, 6'h24, 9'h000, 32'h0000_2000);
    dec(32'hc000_0000, 1'b0, 6'h28, 9'h100, 32'h0);
    dec(32'hffff_fffc, 1'b0, 6'h28, 9'h000, 32'h0);
    bus(1'b1, psd_pkg::PSD_CTRL_OFS, 32'h0000_0500);
    dec(32'h0000_1000, 1'b0, 6'h28, 9'h105, 32'h0);
    $display("kernel test done");
    bus(1'b1, psd_pkg::PSD_CTRL_OFS, 32'h0000_0501);
    bus(1'b0, psd_pkg::PSD_STATE_OFS, 32'h0);
    check(rd_d, 32'h1);
    dec(32'h7fff_fffc, 1'b1, 6'h29, 9'h105, 32'h0);
    dec(32'hdfff_fffc, 1'b0, 6'h28, 9'h105, 32'h0);
    dec(32'h8000_0000, 1'b0, 6'h10, 9'h000, 32'h0);
    dec(32'hbfff_fffc, 1'b0, 6'h10, 9'h000, 32'h0);
    dec(32'he000_0000, 1'b0, 6'h10, 9'h000, 32'h0);
    bus(1'b0, psd_pkg::PSD_IRQ_STAT_OFS, 32'h0);
    check(rd_d & 32'h1, 32'h1);
    $display("supervisor test done");
    bus(1'b1, psd_pkg::PSD_CTRL_OFS, 32'h0000_0502);
    bus(1'b0, psd_pkg::PSD_STATE_OFS, 32'h0);
    check(rd_d, 32'h2);
    dec(32'h7fff_fffc, 1'b0, 6'h28, 9'h105, 32'h0);
    dec(32'hc000_0000, 1'b0, 6'h10, 9'h000, 32'h0);
    $display("user test done");
    bus(1'b1, psd_pkg::PSD_IRQ_STAT_OFS, 32'h7);
    bus(1'b1, psd_pkg::PSD_IRQ_MASK_OFS, 32'h6);
    pipe_u.ev(1'b1, 1'b0, 1'b0, 32'h1000_0040, 1'b0);
    @(posedge clk_i);
    #1;
    check({31'h0, irq_o}, 32'h1);
    dec(32'h8000_0000, 1'b0, 6'h26, 9'h000, 32'h0);
    pipe_u.ev(1'b1, 1'b1, 1'b0, 32'h2000_0080, 1'b0);
    pipe_u.ev(1'b0, 1'b0, 1'b0, 32'h0, 1'b1);
    #1;
    check({redirect_valid_o, redirect_pc_o[30:0]}, 32'ha000_0080);
    bus(1'b0, psd_pkg::PSD_STATE_OFS, 32'h0);
    check(rd_d, 32'h0);
    pipe_u.ev(1'b0, 1'b0, 1'b0, 32'h0, 1'b1);
    bus(1'b0, psd_pkg::PSD_STATE_OFS, 32'h0);
    check(rd_d, 32'h2);
    pipe_u.ev(1'b1, 1'b0, 1'b1, 32'h3000_0000, 1'b0);
    bus(1'b0, psd_pkg::PSD_EPC_OFS, 32'h0);
    check(rd_d, 32'h2000_0080);
    pipe_u.ev(1'b1, 1'b0, 1'b0, 32'h1000_0040, 1'b1);
    #1;
    check({31'h0, redirect_valid_o}, 32'h0);
    bus(1'b1, psd_pkg::PSD_IRQ_MASK_OFS, 32'h0);
    // mask lands on the ack edge; the registered line follows one edge later
    @(posedge clk_i);
    #1;
    check({31'h0, irq_o}, 32'h0);
    bus(1'b1, psd_pkg::PSD_IRQ_STAT_OFS, 32'h7);
    bus(1'b0, psd_pkg::PSD_IRQ_STAT_OFS, 32'h0);
    check(rd_d, 32'h0);
    $display("exception test done");
    results();
  end
endmodule : tb_top
